// ### verilog/prgm_top.sv
// Transceiver pin logic: RGMII lanes, indicators, GPIO, MDIO, interrupt, ref clock, straps
//
// Contract
// - Device delivers received data on four receive lanes.
// - Idle receive lanes carry speed, duplex and link state.
// - Device encodes valid and error on the receive control lane.
// - Device drives receive clock at the rate of the link speed; at 1000 Mbps the pclk divider gives 50 MHz, not 125 MHz.
// - Each indicator takes polarity from its own control bit.
// - Indicator push-pull or single-ended; single-ended drives only its active level.
// - GPIO direction, pull-up and buffer type come from registers.
// - Management data driven push-pull or single-ended by a control bit.
// - Interrupt push-pull or open-drain by bit; open-drain after reset.
// - Interrupt polarity follows invert bit; active low after reset.
// - Open-drain interrupt is forced active low.
// - Reference clock output, optionally locked to receive timing.
// - Chip reset resets all; straps captured at its release.
// - Internal timing derives from the 25 MHz reference.
// - Reference clock strap latched 0 disables output, 1 enables.
// - Three address straps latched at reset give address 0 to 7.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module prgm_top #(
	parameter int GP_N  = 7,
	parameter int IRQ_N = 8
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Transmit pins
	input  wire logic               txc,
	input  wire logic               tx_ctl,
	input  wire logic [3:0]         txd,
	// Transmit core side
	output logic      [7:0]         tx_data,
	output logic                    tx_en,
	output logic                    tx_er,
	output logic                    tx_strobe,
	// Receive core side
	input  wire logic [7:0]         rx_byte,
	input  wire logic               rx_valid,
	input  wire logic               rx_err,
	input  wire prgm_pkg::prgm_link_t link_state,
	output logic                    rx_take,
	// Receive pins
	output logic                    rxc,
	output logic      [3:0]         rxd,
	output logic                    rx_ctl,
	// Indicators
	input  wire logic [4:0]         indicator_on,
	output logic      [4:0]         indicator_o,
	output logic      [4:0]         indicator_oe,
	// General purpose pins
	input  wire logic [GP_N-1:0]    gp_pin_i,
	output logic      [GP_N-1:0]    gp_pin_o,
	output logic      [GP_N-1:0]    gp_pin_oe,
	output logic      [GP_N-1:0]    gp_pin_pu,
	// Management pins and engine
	input  wire logic               mdc,
	input  wire logic               mdio_i,
	output logic                    mdio_o,
	output logic                    mdio_oe,
	input  wire logic               mgmt_drive,
	input  wire logic               mgmt_bit,
	output logic                    mgmt_rise,
	output logic                    mgmt_in,
	// Interrupt
	input  wire logic [IRQ_N-1:0]   irq_event,
	output logic                    int_o,
	output logic                    int_oe,
	// Reference clock and straps
	output logic                    ref_clk_out,
	input  wire logic               ref_clk_out_strap,
	input  wire logic [2:0]         mgmt_addr_strap,
	input  wire logic [4:0]         indicator_strap,
	output logic      [2:0]         mgmt_addr
);
	initial begin
		if (GP_N < 1 || GP_N > 32) $error("prgm_top: GP_N out of range");
		if (IRQ_N < 1 || IRQ_N > 32) $error("prgm_top: IRQ_N out of range");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [5:0]      tx_s;
	logic [1:0]      md_s;
	logic [GP_N-1:0] gp_s;
	logic [8:0]      strap_s;

	prgm_sync #(.W(6)) u_tx_sync (.pclk(pclk), .presetn(presetn), .d({txc, tx_ctl, txd}), .q(tx_s));
	prgm_sync #(.W(2)) u_md_sync (.pclk(pclk), .presetn(presetn), .d({mdc, mdio_i}), .q(md_s));
	prgm_sync #(.W(GP_N)) u_gp_sync (.pclk(pclk), .presetn(presetn), .d(gp_pin_i), .q(gp_s));
	prgm_sync #(.W(9)) u_st_sync (.pclk(pclk), .presetn(presetn),
		.d({ref_clk_out_strap, mgmt_addr_strap, indicator_strap}), .q(strap_s));

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [prgm_pkg::OUTCTL_W-1:0] ctrl_reg;
	logic [GP_N-1:0]  gp_dir_reg, gp_pu_reg, gp_pp_reg, gp_out_reg;
	logic [IRQ_N-1:0] pend_reg, en_reg;
	logic             strap_done_reg, ref_strap_reg;
	logic [1:0]       strap_cnt_reg;
	logic             wr_acc, setup;
	logic             irq_any;

	assign setup   = psel && !penable;
	assign wr_acc  = psel && penable && pready && pwrite;
	assign irq_any = |(pend_reg & en_reg);

	function automatic logic is_mapped(input logic [7:0] a);
		return a == prgm_pkg::ADDR_OUT_CTRL || a == prgm_pkg::ADDR_GP_DIR || a == prgm_pkg::ADDR_GP_PU
			|| a == prgm_pkg::ADDR_GP_BUF || a == prgm_pkg::ADDR_GP_OUT || a == prgm_pkg::ADDR_GP_IN
			|| a == prgm_pkg::ADDR_INT_PEND || a == prgm_pkg::ADDR_INT_EN || a == prgm_pkg::ADDR_STATUS;
	endfunction

	// Straps wait out the synchroniser, then are caught once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt_reg  <= 2'h0;
			strap_done_reg <= 1'b0;
			ref_strap_reg  <= 1'b0;
			mgmt_addr      <= 3'h0;
		end else if (!strap_done_reg) begin
			if (strap_cnt_reg == 2'(prgm_pkg::STRAP_WAIT)) begin
				strap_done_reg <= 1'b1;
				ref_strap_reg  <= strap_s[8];
				mgmt_addr      <= strap_s[7:5];
			end else begin
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
			end
		end
	end

	// Control register; indicator polarity defaults from the straps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= prgm_pkg::OUT_CTRL_RST;
		end else if (!strap_done_reg && strap_cnt_reg == 2'(prgm_pkg::STRAP_WAIT)) begin
			ctrl_reg[prgm_pkg::LEDPOL_LSB +: 5] <= ~strap_s[4:0];
		end else if (wr_acc && paddr == prgm_pkg::ADDR_OUT_CTRL) begin
			ctrl_reg <= pwdata[prgm_pkg::OUTCTL_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gp_dir_reg <= '0;
			gp_pu_reg  <= '0;
			gp_pp_reg  <= '0;
			gp_out_reg <= '0;
			en_reg     <= '0;
		end else if (wr_acc) begin
			if (paddr == prgm_pkg::ADDR_GP_DIR) gp_dir_reg <= pwdata[GP_N-1:0];
			else if (paddr == prgm_pkg::ADDR_GP_PU) gp_pu_reg <= pwdata[GP_N-1:0];
			else if (paddr == prgm_pkg::ADDR_GP_BUF) gp_pp_reg <= pwdata[GP_N-1:0];
			else if (paddr == prgm_pkg::ADDR_GP_OUT) gp_out_reg <= pwdata[GP_N-1:0];
			else if (paddr == prgm_pkg::ADDR_INT_EN) en_reg <= pwdata[IRQ_N-1:0];
		end
	end

	// Pending bits: write one to clear, a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_reg <= '0;
		end else if (wr_acc && paddr == prgm_pkg::ADDR_INT_PEND) begin
			pend_reg <= (pend_reg & ~pwdata[IRQ_N-1:0]) | irq_event;
		end else begin
			pend_reg <= pend_reg | irq_event;
		end
	end

	// ---------------------------------------------------------------
	// APB answer: ready in the first access cycle, no wait states
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !is_mapped(paddr);
			prdata  <= 32'h0;
			if (setup && !pwrite) begin
				if (paddr == prgm_pkg::ADDR_OUT_CTRL) prdata <= 32'(ctrl_reg);
				else if (paddr == prgm_pkg::ADDR_GP_DIR) prdata <= 32'(gp_dir_reg);
				else if (paddr == prgm_pkg::ADDR_GP_PU) prdata <= 32'(gp_pu_reg);
				else if (paddr == prgm_pkg::ADDR_GP_BUF) prdata <= 32'(gp_pp_reg);
				else if (paddr == prgm_pkg::ADDR_GP_OUT) prdata <= 32'(gp_out_reg);
				else if (paddr == prgm_pkg::ADDR_GP_IN) prdata <= 32'(gp_s);
				else if (paddr == prgm_pkg::ADDR_INT_PEND) prdata <= 32'(pend_reg);
				else if (paddr == prgm_pkg::ADDR_INT_EN) prdata <= 32'(en_reg);
				else if (paddr == prgm_pkg::ADDR_STATUS)
					prdata <= 32'({ref_strap_reg, mgmt_addr, link_state});
			end
		end
	end

	// ---------------------------------------------------------------
	// Transmit capture on edges of the sampled transmit clock
	// ---------------------------------------------------------------
	logic       txc_d_reg, tx_ctl_lo_reg;
	logic [3:0] tx_lo_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txc_d_reg     <= 1'b0;
			tx_lo_reg     <= 4'h0;
			tx_ctl_lo_reg <= 1'b0;
			tx_data       <= 8'h0;
			tx_en         <= 1'b0;
			tx_er         <= 1'b0;
			tx_strobe     <= 1'b0;
		end else begin
			txc_d_reg <= tx_s[5];
			tx_strobe <= 1'b0;
			if (tx_s[5] && !txc_d_reg) begin
				tx_lo_reg     <= tx_s[3:0];
				tx_ctl_lo_reg <= tx_s[4];
			end else if (!tx_s[5] && txc_d_reg) begin
				tx_data   <= {tx_s[3:0], tx_lo_reg};
				tx_en     <= tx_ctl_lo_reg;
				tx_er     <= tx_ctl_lo_reg ^ tx_s[4];
				tx_strobe <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Receive lanes
	// ---------------------------------------------------------------
	prgm_pkg::prgm_lane_t lane;

	prgm_rx_lanes u_rx (
		.pclk    (pclk),
		.presetn (presetn),
		.rx_byte (rx_byte),
		.rx_valid(rx_valid),
		.rx_err  (rx_err),
		.lnk     (link_state),
		.rx_take (rx_take),
		.rxc     (rxc),
		.lane    (lane)
	);
	assign rxd    = lane.d;
	assign rx_ctl = lane.ctl;

	// ---------------------------------------------------------------
	// Indicators and general purpose pins
	// ---------------------------------------------------------------
	logic [4:0] led_pol, led_pp;
	assign led_pol = ctrl_reg[prgm_pkg::LEDPOL_LSB +: 5];
	assign led_pp  = ctrl_reg[prgm_pkg::LEDPP_LSB +: 5];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicator_o  <= 5'h0;
			indicator_oe <= 5'h0;
		end else begin
			for (int i = 0; i < 5; i++) begin
				indicator_o[i]  <= indicator_on[i] ? led_pol[i] : ~led_pol[i];
				indicator_oe[i] <= led_pp[i] || indicator_on[i];
			end
		end
	end

	// Single-ended GPIO drives low only; the pull-up gives the high level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gp_pin_o  <= '0;
			gp_pin_oe <= '0;
			gp_pin_pu <= '0;
		end else begin
			gp_pin_o  <= gp_out_reg;
			gp_pin_oe <= gp_dir_reg & (gp_pp_reg | ~gp_out_reg);
			gp_pin_pu <= gp_pu_reg;
		end
	end

	// ---------------------------------------------------------------
	// Management data pin
	// ---------------------------------------------------------------
	logic mdc_d_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdc_d_reg <= 1'b0;
			mgmt_rise <= 1'b0;
			mgmt_in   <= 1'b0;
			mdio_o    <= 1'b0;
			mdio_oe   <= 1'b0;
		end else begin
			mdc_d_reg <= md_s[1];
			// Edges wait for settled synchronisers: their reset level is not the pulled-up idle level
			mgmt_rise <= md_s[1] && !mdc_d_reg && strap_done_reg;
			mgmt_in   <= md_s[0];
			mdio_o    <= mgmt_bit;
			mdio_oe   <= mgmt_drive && (ctrl_reg[prgm_pkg::MDIOPP_BIT] || !mgmt_bit);
		end
	end

	// ---------------------------------------------------------------
	// Interrupt pin
	// ---------------------------------------------------------------
	logic int_pp, int_inv;
	assign int_pp  = ctrl_reg[prgm_pkg::INTPP_BIT];
	assign int_inv = ctrl_reg[prgm_pkg::INTINV_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_o  <= 1'b0;
			int_oe <= 1'b0;
		end else if (int_pp) begin
			int_o  <= irq_any ~^ int_inv;
			int_oe <= 1'b1;
		end else begin
			int_o  <= 1'b0;
			int_oe <= irq_any;
		end
	end

	// ---------------------------------------------------------------
	// Reference clock: free divider, or follows the receive clock
	// ---------------------------------------------------------------
	logic [7:0] ref_cnt_reg;
	logic       ref_on;
	assign ref_on = ref_strap_reg && ctrl_reg[prgm_pkg::REFEN_BIT];

	// Divider runs off pclk, itself derived from the 25 MHz reference
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cnt_reg <= 8'h0;
			ref_clk_out <= 1'b0;
		end else if (!ref_on) begin
			ref_cnt_reg <= 8'h0;
			ref_clk_out <= 1'b0;
		end else if (ctrl_reg[prgm_pkg::REFSYNC_BIT]) begin
			ref_clk_out <= rxc;
		end else if (ref_cnt_reg >= 8'(prgm_pkg::HALF_REF - 1)) begin
			ref_cnt_reg <= 8'h0;
			ref_clk_out <= ~ref_clk_out;
		end else begin
			ref_cnt_reg <= ref_cnt_reg + 8'h1;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	int_od_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!$past(int_pp) && int_oe) |-> !int_o)
		else $error("open-drain interrupt not active low");
	int_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_any && !int_pp && $stable(int_pp)) |=> int_oe && !int_o)
		else $error("interrupt not asserted while pending");
	int_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
		(int_pp && !irq_any) |=> int_oe && (int_o == !$past(int_inv)))
		else $error("idle push-pull interrupt level wrong");
	led_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> indicator_o[0] == ($past(indicator_on[0]) ? $past(led_pol[0]) : !$past(led_pol[0])))
		else $error("indicator level ignores polarity");
	led_single_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!led_pp[1] && !indicator_on[1]) |=> !indicator_oe[1])
		else $error("single-ended indicator drives inactive level");
	pend_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_event[0] |=> pend_reg[0])
		else $error("interrupt event lost");
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready ##1 !pready)
		else $error("apb ready not one access cycle");
	strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		strap_done_reg |=> strap_done_reg && $stable(mgmt_addr) && $stable(ref_strap_reg))
		else $error("strap value changed after capture");
	ref_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ref_strap_reg |=> !ref_clk_out)
		else $error("reference clock runs with strap low");
	mdio_od_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl_reg[prgm_pkg::MDIOPP_BIT] && mgmt_bit) |=> !mdio_oe)
		else $error("single-ended management line drives high");
	gp_od_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!gp_dir_reg[0]) |=> !gp_pin_oe[0])
		else $error("input gpio is driven");
	tx_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_strobe |=> !tx_strobe)
		else $error("transmit strobe longer than one cycle");
endmodule

// ### verilog/prgm_pkg.sv
// Package for the transceiver pin logic: rates, register map, fields, carriers
package prgm_pkg;

	// ---------------------------------------------------------------
	// Clock rates
	// ---------------------------------------------------------------
	localparam int PCLK_KHZ    = 100000;
	localparam int XTAL_KHZ    = 25000;
	localparam int RATE_G_KHZ  = 125000;
	localparam int RATE_F_KHZ  = 25000;
	localparam int RATE_T_KHZ  = 2500;
	localparam int REF_KHZ     = 125000;

	// Half period in pclk cycles, rounded down, never below one
	function automatic int half_cnt(input int khz);
		int c;
		c = PCLK_KHZ / (2 * khz);
		return (c < 1) ? 1 : c;
	endfunction

	localparam int HALF_G      = half_cnt(RATE_G_KHZ);
	localparam int HALF_F      = half_cnt(RATE_F_KHZ);
	localparam int HALF_T      = half_cnt(RATE_T_KHZ);
	localparam int HALF_REF    = half_cnt(REF_KHZ);
	localparam int STRAP_WAIT  = 2;

	// ---------------------------------------------------------------
	// Link speed codes, as carried in band
	// ---------------------------------------------------------------
	localparam logic [1:0] SPEED_10   = 2'h0;
	localparam logic [1:0] SPEED_100  = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_OUT_CTRL = 8'h00;
	localparam logic [7:0] ADDR_GP_DIR   = 8'h04;
	localparam logic [7:0] ADDR_GP_PU    = 8'h08;
	localparam logic [7:0] ADDR_GP_BUF   = 8'h0c;
	localparam logic [7:0] ADDR_GP_OUT   = 8'h10;
	localparam logic [7:0] ADDR_GP_IN    = 8'h14;
	localparam logic [7:0] ADDR_INT_PEND = 8'h18;
	localparam logic [7:0] ADDR_INT_EN   = 8'h1c;
	localparam logic [7:0] ADDR_STATUS   = 8'h20;

	// Output control fields
	localparam int LEDPOL_LSB  = 0;
	localparam int LEDPP_LSB   = 5;
	localparam int MDIOPP_BIT  = 10;
	localparam int INTPP_BIT   = 11;
	localparam int INTINV_BIT  = 12;
	localparam int REFEN_BIT   = 13;
	localparam int REFSYNC_BIT = 14;
	localparam int OUTCTL_W    = 15;
	localparam logic [OUTCTL_W-1:0] OUT_CTRL_RST = 15'h2000;

	// Status fields
	localparam int ST_LINK_BIT  = 0;
	localparam int ST_SPEED_LSB = 1;
	localparam int ST_DUPLEX    = 3;
	localparam int ST_ADDR_LSB  = 4;
	localparam int ST_REFSTRAP  = 7;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       duplex;
		logic [1:0] speed;
		logic       link;
	} prgm_link_t;

	typedef struct packed {
		logic [3:0] d;
		logic       ctl;
	} prgm_lane_t;

endpackage

// ### verilog/prgm_sync.sv
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module prgm_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	initial begin
		if (W < 1) $error("prgm_sync: width must be at least one");
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ### verilog/prgm_rx_lanes.sv
// Receive clock and double-edge lane generator toward the MAC
`timescale 1ns/1ps
module prgm_rx_lanes (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Core side
	input  wire logic [7:0]         rx_byte,
	input  wire logic               rx_valid,
	input  wire logic               rx_err,
	input  wire prgm_pkg::prgm_link_t lnk,
	output logic                    rx_take,
	// Pins
	output logic                    rxc,
	output prgm_pkg::prgm_lane_t    lane
);
	logic [15:0] cnt_reg;
	logic [15:0] half;
	logic [3:0]  hi_nib_reg;
	logic        hi_ctl_reg;
	logic        wrap;
	logic        idle;

	always_comb begin
		if (lnk.speed == prgm_pkg::SPEED_1000) half = 16'(prgm_pkg::HALF_G);
		else if (lnk.speed == prgm_pkg::SPEED_100) half = 16'(prgm_pkg::HALF_F);
		else half = 16'(prgm_pkg::HALF_T);
	end

	assign wrap = (cnt_reg >= half - 16'h1);
	// Carrier events (error without valid) carry core data, not status
	assign idle = !rx_valid && !rx_err;

	// ---------------------------------------------------------------
	// Rate divider
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 16'h0;
			rxc     <= 1'b0;
		end else if (wrap) begin
			cnt_reg <= 16'h0;
			rxc     <= ~rxc;
		end else begin
			cnt_reg <= cnt_reg + 16'h1;
		end
	end

	// ---------------------------------------------------------------
	// Lanes: low nibble with the rising edge, high with the falling
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane       <= '0;
			hi_nib_reg <= 4'h0;
			hi_ctl_reg <= 1'b0;
			rx_take    <= 1'b0;
		end else begin
			rx_take <= 1'b0;
			if (wrap && !rxc) begin
				rx_take <= 1'b1;
				if (idle) begin
					lane.d     <= lnk;
					hi_nib_reg <= lnk;
				end else begin
					lane.d     <= rx_byte[3:0];
					hi_nib_reg <= rx_byte[7:4];
				end
				lane.ctl   <= rx_valid;
				hi_ctl_reg <= rx_valid ^ rx_err;
			end else if (wrap && rxc) begin
				lane.d   <= hi_nib_reg;
				lane.ctl <= hi_ctl_reg;
			end
		end
	end

	inband_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wrap && !rxc && idle) |=> (lane.d == $past(lnk)) && !lane.ctl)
		else $error("in-band status missing on idle lanes");
	rxc_half_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wrap && lnk.speed == prgm_pkg::SPEED_100) ##1 (lnk.speed == prgm_pkg::SPEED_100) [*2]
			|-> ($past(rxc) != $past(rxc, 2)) && $stable(rxc) ##1 !$stable(rxc))
		else $error("receive clock half period wrong at 100 Mbps");
endmodule

// ### tb/prgm_mac_model.sv
// MAC model driving the RGMII transmit lanes
`timescale 1ns/1ps
module prgm_mac_model (
	// Transmit pins
	output logic       txc,
	output logic       tx_ctl,
	output logic [3:0] txd,
	// Management pins
	output logic       mdc,
	output logic       mdio
);
	initial begin
		mdc = 1'h1;
		mdio = 1'h1;
		txc = 1'h0;
		tx_ctl = 1'h0;
		txd = 4'h0;
	end
	// One byte with enable set; the clock stands still between frames
	task automatic send(input logic [7:0] b);
		#2 txd = b[3:0];
		tx_ctl = 1'h1;
		#20 txc = 1'h1;
		#20 txd = b[7:4];
		#20 txc = 1'h0;
		#20 txd = ~b[7:4];
		tx_ctl = 1'h0;
	endtask
	// One management clock pulse with one data bit; the clock idles high
	task automatic mgmt_send(input logic v);
		#2 mdio = v;
		mdc = 1'h0;
		#40 mdc = 1'h1;
	endtask
endmodule

// ### tb/tb.sv
// Testbench: registers, straps, interrupt, indicators and RGMII lanes
`timescale 1ns/1ps
module tb;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e, r;
	logic [7:0] paddr = 8'h00, rx_byte = 8'h00, irq_event = 8'h00, tx_data, b;
	logic [31:0] pwdata = 32'h0, prdata, q, v;
	logic pready, pslverr, rx_valid = 1'h0, rx_err = 1'h0, rxc, rx_ctl, tx_en, tx_er, tx_strobe, int_o, int_oe;
	logic txc, tx_ctl, ref_clk_out, rx_take, ref_clk_out_strap = 1'h1;
	logic [3:0] rxd, txd;
	logic [4:0] indicator_on = 5'h00, indicator_o, indicator_oe, indicator_strap = 5'h0a, oe;
	logic [2:0] mgmt_addr_strap = 3'h5, mgmt_addr;
	logic mdc, mdio, md_drv = 1'h0, md_bit = 1'h0, mdio_o, mdio_oe, mgmt_rise, mgmt_in;
	logic [6:0] gp_i = 7'h00, gp_o, gp_oe, gp_pu;
	logic [31:0] g[4];
	prgm_pkg::prgm_link_t link_state = 4'hb;
	int mismatches = 0, samples_checked = 0, cyc = 0, t, k, nr = 0;
	int hv[3] = '{prgm_pkg::HALF_T, prgm_pkg::HALF_F, prgm_pkg::HALF_G};
	int unsigned seed = 35;
	logic [7:0] txq[$];
	prgm_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .txc,
		.tx_ctl, .txd, .tx_data, .tx_en, .tx_er, .tx_strobe, .rx_byte, .rx_valid, .rx_err, .link_state, .rx_take,
		.rxc, .rxd, .rx_ctl, .indicator_on, .indicator_o, .indicator_oe, .gp_pin_i(gp_i), .gp_pin_o(gp_o),
		.gp_pin_oe(gp_oe), .gp_pin_pu(gp_pu), .mdc, .mdio_i(mdio), .mdio_o, .mdio_oe, .mgmt_drive(md_drv),
		.mgmt_bit(md_bit), .mgmt_rise, .mgmt_in, .irq_event, .int_o, .int_oe, .ref_clk_out,
		.ref_clk_out_strap, .mgmt_addr_strap, .indicator_strap, .mgmt_addr);
	prgm_mac_model mac (.txc, .tx_ctl, .txd, .mdc, .mdio);
	always #5 pclk = ~pclk;
	// A false edge after reset shows up as an extra pulse
	always @(posedge pclk) nr += int'(mgmt_rise === 1'h1);
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic finish_test();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait; a hang counts as a mismatch
	task automatic wait_for(ref logic s, input logic lvl);
		for (k = 0; k < 200 && s !== lvl; k++) begin
			@(posedge pclk);
			cyc++;
		end
		if (k == 200) begin
			mismatches++;
			finish_test();
		end
	endtask
	task automatic rise();
		wait_for(rxc, 1'h0);
		wait_for(rxc, 1'h1);
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk) begin
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			psel <= 1'h1;
		end
		@(posedge pclk) penable <= 1'h1;
		@(posedge pclk);
		wait_for(pready, 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		repeat (6) @(posedge pclk);
		apb(prgm_pkg::ADDR_OUT_CTRL, 1'h0, 32'h0);
		chk(q, 32'h2015);
		apb(prgm_pkg::ADDR_STATUS, 1'h0, 32'h0);
		chk(q, 32'hdb);
		chk(mgmt_addr, 3'h5);
		apb(8'h40, 1'h0, 32'h0);
		chk(e, 1'h1);
		r = ref_clk_out;
		t = 0;
		repeat (8) begin
			@(posedge pclk);
			t += int'(ref_clk_out !== r);
			r = ref_clk_out;
		end
		chk(t, 8);
		apb(prgm_pkg::ADDR_INT_EN, 1'h1, 32'h1);
		@(posedge pclk) irq_event <= 8'h01;
		@(posedge pclk) irq_event <= 8'h00;
		repeat (3) @(posedge pclk);
		chk({int_oe, int_o}, 2'h2);
		apb(prgm_pkg::ADDR_INT_PEND, 1'h1, 32'h1);
		repeat (3) @(posedge pclk);
		chk(int_oe, 1'h0);
		repeat (4) begin
			v = rnd() & 32'h3ff;
			apb(prgm_pkg::ADDR_OUT_CTRL, 1'h1, v | 32'h2000);
			@(posedge pclk) indicator_on <= 5'(rnd());
			repeat (3) @(posedge pclk);
			oe = v[9:5] | indicator_on;
			chk(indicator_oe, oe);
			chk(indicator_o & oe, ~(indicator_on ^ v[4:0]) & oe);
		end
		repeat (3) begin
			b = 8'(rnd());
			txq.push_back(b);
			fork mac.send(b); join_none
			wait_for(tx_strobe, 1'h1);
			chk({tx_en, tx_er, tx_data}, {2'h2, txq.pop_front()});
			repeat (4) @(posedge pclk);
		end
		foreach (hv[i]) begin
			@(posedge pclk) link_state.speed <= 2'(i);
			rise();
			rise();
			t = cyc;
			chk({rx_ctl, rxd}, {1'h0, link_state});
			rise();
			chk(cyc - t, 2 * hv[i]);
		end
		@(posedge pclk) begin
			rx_byte <= 8'(rnd());
			rx_valid <= 1'h1;
			rx_err <= 1'h1;
		end
		rise();
		rise();
		chk({rx_ctl, rxd}, {1'h1, rx_byte[3:0]});
		wait_for(rxc, 1'h0);
		chk({rx_ctl, rxd}, {1'h0, rx_byte[7:4]});
		repeat (2) begin
			v = rnd();
			fork mac.mgmt_send(v[0]); join_none
			wait_for(mgmt_rise, 1'h1);
			chk(mgmt_in, v[0]);
			@(posedge pclk) begin
				md_drv <= 1'h1;
				md_bit <= v[1];
			end
			repeat (3) @(posedge pclk);
			chk(mdio_oe, !v[1]);
		end
		apb(prgm_pkg::ADDR_OUT_CTRL, 1'h1, 32'h7c00);
		repeat (3) @(posedge pclk);
		chk({mdio_oe, int_oe, int_o}, {1'h1, 2'h2});
		@(posedge pclk) irq_event <= 8'h01;
		@(posedge pclk) irq_event <= 8'h00;
		repeat (3) begin
			r = rxc;
			@(posedge pclk);
			chk(ref_clk_out, r);
		end
		chk({int_oe, int_o}, 2'h3);
		@(posedge pclk) gp_i <= 7'(rnd());
		foreach (g[i]) begin
			g[i] = rnd();
			apb(8'(prgm_pkg::ADDR_GP_DIR + 4 * i), 1'h1, g[i]);
		end
		apb(prgm_pkg::ADDR_GP_IN, 1'h0, 32'h0);
		chk(q, gp_i);
		chk(gp_oe, g[0][6:0] & (g[2][6:0] | ~g[3][6:0]));
		chk({gp_pu, gp_o}, {g[1][6:0], g[3][6:0]});
		chk(nr, 2);
		finish_test();
	end
endmodule
